// ---- anis_pkg.sv ----
/*
 package for the align/notify insertion scheduler: rate codes, periods,
 stream carrier struct. assumes a 32-bit dword datapath with a k-flag.
*/
package anis_pkg;

	// ----------------------------------------------------------------
	// link and connection rates
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {
		ANIS_RATE_G1 = 1'b0,
		ANIS_RATE_G2 = 1'b1
	} anis_rate_e;

	// ----------------------------------------------------------------
	// insertion periods (dwords) and counts per period
	// ----------------------------------------------------------------
	localparam int          CNT_W          = 12;
	localparam logic [11:0] SKEW_PER_G2    = 12'hfff;  // 4096 dwords, minus one
	localparam logic [11:0] SKEW_PER_G1    = 12'h07ff; // 2048 dwords, minus one
	localparam logic [1:0]  SKEW_NUM_G2    = 2'h2;
	localparam logic [1:0]  SKEW_NUM_G1    = 2'h1;
	localparam logic [11:0] THR_PER        = 12'h00ff; // 256 dwords, minus one
	localparam logic [1:0]  THR_NUM        = 2'h2;
	localparam logic [1:0]  PEND_MAX       = 2'h3;

	// ----------------------------------------------------------------
	// primitive selection and dword carrier
	// ----------------------------------------------------------------
	localparam logic [31:0] PRIM_ALIGN_DEF  = 32'h0000_0000; // arbitrary, set by user
	localparam logic [31:0] PRIM_NOTIFY_DEF = 32'h0000_0001; // arbitrary, set by user
	localparam int          FIFO_DEPTH      = 4;

	typedef struct packed {
		logic        k;
		logic [31:0] data;
	} anis_dword_s;

	localparam int DW_W = 33;

endpackage

// ---- anis_fifo.sv ----
/*
 small valid/ready fifo, parameterised width and depth.
 assumes single clock, async active-low reset.
*/
`timescale 1ns/10ps
module anis_fifo #(
	parameter int W = 33,
	parameter int D = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp_q;
	logic [AW-1:0] rp_q;
	logic [AW:0]   cnt_q;
	logic          push;
	logic          pop;

	// full compare needs the count's own width: depth does not fit in AW bits
	assign in_ready  = (cnt_q != (AW+1)'(D)) ? 1'b1 : 1'b0;
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem[rp_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wp_q <= (wp_q == AW'(D - 1)) ? '0 : wp_q + 1'b1;
			end
			if (pop) begin
				rp_q <= (rp_q == AW'(D - 1)) ? '0 : rp_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// no overflow beyond depth
	fifo_bound_a: assert property (@(posedge clk) disable iff (!rstn)
		cnt_q <= (AW+1)'(D)) else $error("fifo count above depth");

endmodule

// ---- anis_sched.sv ----
/*
 align/notify insertion scheduler: pulls link-layer dwords through a fifo
 and inserts deletable primitives at the rates set by link rate,
 connection rate and stp target flag. assumes rate inputs are static
 during a connection and come from logic on clk.
*/
// Function
// - each insertion is align or notify; rates counted per dword window.
// - g2 link, g2 connection, non-stp: two per 4096 for clock skew.
// - stp target at g2/g2 adds two per 256 for throttling.
// - g2 link, g1 connection: one every 2 dwords plus skew insertions.
// - g2 link, g1 connection, stp: skew, rate match and throttle combined.
// - g1 link, g1 connection, non-stp: one per 2048 for clock skew.
// - g1/g1 to stp target: skew one per 2048 plus two per 256.
`timescale 1ns/10ps
module anis_sched (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rstn,
	// configuration
	input  wire anis_pkg::anis_rate_e  link_rate,
	input  wire anis_pkg::anis_rate_e  conn_rate,
	input  wire logic                  to_stp,
	input  wire logic                  use_notify,
	input  wire logic [31:0]           prim_align,
	input  wire logic [31:0]           prim_notify,
	// link layer side
	input  wire logic                  ll_valid,
	output logic                       ll_ready,
	input  wire anis_pkg::anis_dword_s ll_dword,
	// phy side, one dword per clock
	output anis_pkg::anis_dword_s      tx_dword_q,
	output logic                       tx_ins_q,
	output logic                       tx_idle_q
);
	// ----------------------------------------------------------------
	// fifo between link layer and scheduler
	// ----------------------------------------------------------------
	logic                  f_valid;
	logic                  f_ready;
	anis_pkg::anis_dword_s f_dword;

	anis_fifo #(
		.W (anis_pkg::DW_W),
		.D (anis_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk       (clk),
		.rstn      (rstn),
		.in_valid  (ll_valid),
		.in_ready  (ll_ready),
		.in_data   (ll_dword),
		.out_valid (f_valid),
		.out_ready (f_ready),
		.out_data  (f_dword)
	);

	// ----------------------------------------------------------------
	// window counters, one per dword slot
	// ----------------------------------------------------------------
	logic [anis_pkg::CNT_W-1:0] skew_cnt_q;
	logic [anis_pkg::CNT_W-1:0] thr_cnt_q;
	logic [anis_pkg::CNT_W-1:0] skew_per;
	logic [1:0]                 skew_num;
	logic                       rm_en;
	logic                       thr_en;
	logic                       skew_wrap;
	logic                       thr_wrap;

	always_comb begin
		skew_per = (link_rate == anis_pkg::ANIS_RATE_G2) ? anis_pkg::SKEW_PER_G2
		                                                 : anis_pkg::SKEW_PER_G1;
		skew_num = (link_rate == anis_pkg::ANIS_RATE_G2) ? anis_pkg::SKEW_NUM_G2
		                                                 : anis_pkg::SKEW_NUM_G1;
		rm_en    = (link_rate == anis_pkg::ANIS_RATE_G2) &&
		           (conn_rate == anis_pkg::ANIS_RATE_G1);
		thr_en   = to_stp;
	end

	assign skew_wrap = (skew_cnt_q == skew_per);
	assign thr_wrap  = (thr_cnt_q == anis_pkg::THR_PER);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			skew_cnt_q <= '0;
			thr_cnt_q  <= '0;
		end else begin
			skew_cnt_q <= skew_wrap ? '0 : skew_cnt_q + 1'b1;
			thr_cnt_q  <= thr_wrap ? '0 : thr_cnt_q + 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// pending insertion credits
	// ----------------------------------------------------------------
	// credits owed at window start; paid back in following slots so a
	// window always carries its full quota even with a busy stream
	logic [1:0] skew_pend_q;
	logic [1:0] thr_pend_q;
	logic       rm_phase_q;
	logic       ins_slot;
	logic       take_skew;
	logic       take_thr;

	// rate matching: every other slot is an insertion; owed skew/throttle credits
	// also insert in the next slots whatever the phase; one owed on a rate-match slot is paid by that insertion
	assign ins_slot  = (rm_en && rm_phase_q) || (skew_pend_q != '0) || (thr_pend_q != '0);
	assign take_skew = ins_slot && (skew_pend_q != '0);
	assign take_thr  = ins_slot && !take_skew && (thr_pend_q != '0);

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			skew_pend_q <= '0;
			thr_pend_q  <= '0;
			rm_phase_q  <= 1'b1;
		end else begin
			// first slot after reset or enable is an insertion, so no two
			// payload slots ever follow each other at the slow connection
			rm_phase_q <= rm_en ? ~rm_phase_q : 1'b1;
			if (skew_wrap) begin
				skew_pend_q <= skew_pend_q + skew_num - 2'(take_skew);
			end else if (take_skew) begin
				skew_pend_q <= skew_pend_q - 1'b1;
			end
			if (thr_wrap && thr_en) begin
				thr_pend_q <= thr_pend_q + anis_pkg::THR_NUM - 2'(take_thr);
			end else if (take_thr) begin
				thr_pend_q <= thr_pend_q - 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// output slot
	// ----------------------------------------------------------------
	assign f_ready = !ins_slot;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			tx_dword_q <= '0;
			tx_ins_q   <= 1'b0;
			tx_idle_q  <= 1'b1;
		end else begin
			if (ins_slot) begin
				tx_dword_q.k    <= 1'b1;
				tx_dword_q.data <= use_notify ? prim_notify : prim_align;
				tx_ins_q        <= 1'b1;
				tx_idle_q       <= 1'b0;
			end else if (f_valid) begin
				tx_dword_q <= f_dword;
				tx_ins_q   <= 1'b0;
				tx_idle_q  <= 1'b0;
			end else begin
				tx_dword_q <= '0;
				tx_ins_q   <= 1'b0;
				tx_idle_q  <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	skew_credit_a: assert property (@(posedge clk) disable iff (!rstn)
		skew_wrap && link_rate == anis_pkg::ANIS_RATE_G2 && skew_pend_q == '0
		|=> skew_pend_q == 2'h2) else $error("g2 skew quota not loaded");

	skew_g1_a: assert property (@(posedge clk) disable iff (!rstn)
		skew_wrap && link_rate == anis_pkg::ANIS_RATE_G1 && skew_pend_q == '0
		|=> skew_pend_q == 2'h1) else $error("g1 skew quota not loaded");

	skew_pay_a: assert property (@(posedge clk) disable iff (!rstn)
		skew_pend_q != '0 |=> tx_ins_q) else $error("skew credit not paid");

	thr_load_a: assert property (@(posedge clk) disable iff (!rstn)
		thr_wrap && to_stp && thr_pend_q == '0 |=> thr_pend_q == 2'h2)
		else $error("throttle quota not loaded");

	thr_off_a: assert property (@(posedge clk) disable iff (!rstn)
		!to_stp && thr_pend_q == '0 |=> thr_pend_q == '0)
		else $error("throttle without stp target");

	rm_every2_a: assert property (@(posedge clk) disable iff (!rstn)
		rm_en && $past(rm_en) ##1 rm_en |-> tx_ins_q || $past(tx_ins_q))
		else $error("rate match gap over two dwords");

	rm_mix_a: assert property (@(posedge clk) disable iff (!rstn)
		rm_en && rm_phase_q |=> tx_ins_q && tx_dword_q.k)
		else $error("rate match slot not inserted");

	ins_prim_a: assert property (@(posedge clk) disable iff (!rstn)
		ins_slot && use_notify |=> tx_dword_q.data == $past(prim_notify))
		else $error("inserted dword not the notify primitive");

	ins_align_a: assert property (@(posedge clk) disable iff (!rstn)
		ins_slot && !use_notify |=> tx_dword_q.data == $past(prim_align))
		else $error("inserted dword not the align primitive");

endmodule

// ---- anis_phy_model.sv ----
/*
 far-side phy model for the insertion scheduler: takes the transmit
 stream and hands only payload dwords to its own link layer.
 assumes one dword per clock on the scheduler's registered outputs.
*/
`timescale 1ns/10ps
module anis_phy_model (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rstn,
	// transmit stream from the scheduler
	input  wire anis_pkg::anis_dword_s tx_dword_q,
	input  wire logic                  tx_ins_q,
	input  wire logic                  tx_idle_q,
	// dwords passed to the far link layer
	output logic                       rx_valid_q,
	output anis_pkg::anis_dword_s      rx_dword_q
);
	// ----------------------------------------------------------------
	// discard of inserted primitives
	// ----------------------------------------------------------------
	// insertions carry no payload, so dropping them loses no data
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rx_valid_q <= 1'b0;
			rx_dword_q <= '0;
		end else begin
			rx_valid_q <= !tx_ins_q && !tx_idle_q;
			rx_dword_q <= tx_dword_q;
		end
	end
endmodule

// ---- testbench.sv ----
/*
 self-checking bench for the insertion scheduler: counts insertions per
 rate setting, then streams data through a full fifo to the phy model.
 assumes the scheduler's package and the phy model are compiled first.
*/
`timescale 1ns/10ps
module testbench;
	typedef struct packed {
		anis_pkg::anis_rate_e link;
		anis_pkg::anis_rate_e conn;
		logic                 stp;
		logic                 ntf;
		logic [15:0]          lo;
		logic [15:0]          hi;
	} anis_row_s;
	localparam anis_pkg::anis_rate_e G1 = anis_pkg::ANIS_RATE_G1;
	localparam anis_pkg::anis_rate_e G2 = anis_pkg::ANIS_RATE_G2;
	localparam logic [31:0]          PA = 32'ha5a5_0001;
	localparam logic [31:0]          PN = 32'h5a5a_0002;
	logic                  clk, rstn, to_stp, use_notify, ll_valid, ll_ready;
	logic                  tx_ins_q, tx_idle_q, rx_valid_q, gap, full, r;
	anis_pkg::anis_rate_e  link_rate, conn_rate;
	anis_pkg::anis_dword_s ll_dword, tx_dword_q, rx_dword_q;
	logic [15:0]           n, i, rx_idx;
	int                    error_cnt, checks_done, idle_run, t;
	anis_row_s             rows [6];

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic anis_pkg::anis_dword_s mk(input logic [15:0] x);
		mk = {1'b0, 16'h0000, x};
	endfunction
	task chk(input logic [32:0] got, input logic [32:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wrap_up;
		if (error_cnt == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task do_reset;
		rstn = 1'b0;
		repeat (5) @(negedge clk);
		chk(tx_dword_q, 33'h0000_0000);
		chk({31'h0, tx_ins_q, tx_idle_q}, 33'h0000_0001);
		rstn = 1'b1;
	endtask

	// ----------------------------------------------------------------
	// clock, design and far side
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	anis_sched dut (.clk(clk), .rstn(rstn), .link_rate(link_rate), .conn_rate(conn_rate),
		.to_stp(to_stp), .use_notify(use_notify), .prim_align(PA), .prim_notify(PN),
		.ll_valid(ll_valid), .ll_ready(ll_ready), .ll_dword(ll_dword),
		.tx_dword_q(tx_dword_q), .tx_ins_q(tx_ins_q), .tx_idle_q(tx_idle_q));
	anis_phy_model phy (.clk(clk), .rstn(rstn), .tx_dword_q(tx_dword_q), .tx_ins_q(tx_ins_q),
		.tx_idle_q(tx_idle_q), .rx_valid_q(rx_valid_q), .rx_dword_q(rx_dword_q));
	always @(negedge clk) begin
		if (rx_valid_q === 1'b1) begin
			chk(rx_dword_q, mk(rx_idx));
			rx_idx++;
		end
	end

	// ----------------------------------------------------------------
	// sequence
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0;
		{to_stp, use_notify, ll_valid, rx_idx} = '0;
		{link_rate, conn_rate, ll_dword} = '0;
		{error_cnt, checks_done} = '0;
		// bounds over 8192 dwords; the last window's credits may not be paid yet
		rows[0] = '{G2, G2, 1'b0, 1'b0, 16'h0002, 16'h0004};
		rows[1] = '{G2, G2, 1'b1, 1'b1, 16'h003e, 16'h0044};
		rows[2] = '{G2, G1, 1'b0, 1'b0, 16'h0fff, 16'h1044};
		rows[3] = '{G2, G1, 1'b1, 1'b1, 16'h0fff, 16'h1044};
		rows[4] = '{G1, G1, 1'b0, 1'b1, 16'h0002, 16'h0004};
		rows[5] = '{G1, G1, 1'b1, 1'b0, 16'h003e, 16'h0044};
		for (int k = 0; k < 6; k++) begin
			{link_rate, conn_rate, to_stp, use_notify} = rows[k][35:32];
			do_reset();
			{n, gap, idle_run} = '0;
			repeat (8192) begin
				@(negedge clk);
				if (tx_ins_q === 1'b1) begin
					n++;
					idle_run = 0;
					chk(tx_dword_q, {1'b1, rows[k].ntf ? PN : PA});
				end else begin
					idle_run++;
					chk({32'h0, tx_idle_q}, 33'h0000_0001);
				end
				if (idle_run > 1)
					gap = 1'b1;
			end
			chk({32'h0, n >= rows[k].lo && n <= rows[k].hi}, 33'h1);
			if (rows[k].link != rows[k].conn)
				chk({32'h0, gap}, 33'h0000_0000);
		end
		// slow connection drains at half rate, so the fifo must refuse
		{link_rate, conn_rate, to_stp, use_notify} = {G2, G1, 2'b10};
		do_reset();
		{i, full} = '0;
		@(negedge clk);
		ll_valid = 1'b1;
		ll_dword = mk(16'h0000);
		r = ll_ready;
		for (t = 0; t < 400 && i < 20; t++) begin
			@(negedge clk);
			if (r) begin
				i++;
				ll_dword = mk(i);
			end else
				full = 1'b1;
			ll_valid = (i < 20);
			r = ll_ready;
		end
		chk({17'h0, i}, 33'h0000_0014);
		chk({32'h0, full}, 33'h0000_0001);
		for (t = 0; t < 200 && rx_idx < 20; t++)
			@(negedge clk);
		chk({17'h0, rx_idx}, 33'h0000_0014);
		wrap_up();
	end
endmodule
